//--- rtl/spwm_timer.sv
// How it works
// - Two units each drive six PWM outputs, every channel running on its own unless its pair is cascaded.
// - Each channel counter ticks on the clock, or the clock divided by 2, 4 or 8.
// - Pairs 1:0, 3:2, 5:4 cascade into one 16-bit timer, odd channel high.
// - Single-pulse mode gives duty from 0/255 to 255/255 in 1/255 steps.
// - Single-pulse carrier is the counter clock over a 255-count period.
// - Cascaded mode gives duty from 0/65535 to 65535/65535.
// - Cascaded carrier is the counter clock over a 65535-count period.
// - Pulse-division mode gives duty from 0/16 to 15/16.
// - Pulse-division carrier is the counter clock over a 16-count period.
// - Every output has its own enable and its own direct or inverted choice.
// - Mode bit 6 cascades channels 0 and 1, channel 1 as upper byte.
// - Mode bits 5 to 0 pick single-pulse (0) or pulse-division (1) per channel.
`timescale 1ns/1ns
module spwm_timer (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic o_hreadyout,
   output logic o_hresp,
   output logic [31:0] o_hrdata,
   output logic [11:0] o_pwm
);

   ////////////////////////////////////////////////////////////////////////////////
   // State.

   spwm_pkg::spwm_unit_cfg_type cfg [spwm_pkg::UNITS];
   spwm_pkg::spwm_unit_cfg_type next_cfg [spwm_pkg::UNITS];
   logic [7:0] duty [spwm_pkg::NCH];
   logic [7:0] next_duty [spwm_pkg::NCH];
   logic [7:0] cnt [spwm_pkg::NCH];
   logic [7:0] next_cnt [spwm_pkg::NCH];
   logic [2:0] presc [spwm_pkg::UNITS];
   logic [2:0] next_presc [spwm_pkg::UNITS];
   logic [11:0] next_pwm;
   logic [11:0] wave;
   logic [11:0] tick;
   logic [5:0] cascade;
   logic wr_pend;
   logic next_wr_pend;
   logic [7:0] wr_addr;
   logic [7:0] next_wr_addr;
   logic [31:0] next_hrdata;
   logic accept;
   logic mapped;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus slave.

   // The slave never stretches a transfer and never reports an error.
   assign o_hreadyout = 1'b1;
   assign o_hresp = 1'b0;
   assign accept = i_hsel && i_htrans[1] && i_hready;
   assign mapped = (i_haddr[31:7] == 25'h0) && (i_haddr[5:2] <= spwm_pkg::WORD_STATUS);

   // Read data is formed in the address phase so that it comes from a flip-flop
   // in the data phase; a write still pending in that same cycle is not yet seen.
   always_comb begin
      int u;
      int k;
      u = 0;
      k = 0;
      next_hrdata = 32'h0;
      next_wr_pend = 1'b0;
      next_wr_addr = wr_addr;
      if (accept && mapped) begin
         u = int'(i_haddr[6]);
         next_wr_pend = i_hwrite;
         next_wr_addr = i_haddr[7:0];
         if (!i_hwrite) begin
            unique case (i_haddr[5:2])
               spwm_pkg::WORD_MODE: next_hrdata = {24'h0, cfg[u].mode_control_c};
               spwm_pkg::WORD_PAIR: next_hrdata = {30'h0, cfg[u].pair_select};
               spwm_pkg::WORD_CLOCK: next_hrdata = {20'h0, cfg[u].clock_select};
               spwm_pkg::WORD_OUTPUT: next_hrdata = {18'h0, cfg[u].out_invert, 2'h0,
                  cfg[u].out_enable};
               spwm_pkg::WORD_STATUS: next_hrdata = {26'h0, o_pwm[u*spwm_pkg::CHANS +: 6]};
               default: begin
                  k = u * spwm_pkg::CHANS + int'(i_haddr[5:2]) - int'(spwm_pkg::WORD_DUTY0);
                  next_hrdata = {24'h0, duty[k]};
               end
            endcase
         end
      end
   end

   // Register writes land in the data phase; unmapped addresses were dropped above.
   always_comb begin
      int u;
      int k;
      logic [3:0] w;
      u = int'(wr_addr[6]);
      w = wr_addr[5:2];
      k = 0;
      next_cfg = cfg;
      next_duty = duty;
      if (wr_pend) begin
         unique case (w)
            spwm_pkg::WORD_MODE: next_cfg[u].mode_control_c = i_hwdata[7:0];
            spwm_pkg::WORD_PAIR: next_cfg[u].pair_select = i_hwdata[1:0];
            spwm_pkg::WORD_CLOCK: next_cfg[u].clock_select = i_hwdata[11:0];
            spwm_pkg::WORD_OUTPUT: begin
               next_cfg[u].out_enable = i_hwdata[5:0];
               next_cfg[u].out_invert = i_hwdata[spwm_pkg::INVERT_POS +: 6];
            end
            spwm_pkg::WORD_STATUS: next_cfg[u] = cfg[u];
            default: begin
               k = u * spwm_pkg::CHANS + int'(w) - int'(spwm_pkg::WORD_DUTY0);
               next_duty[k] = i_hwdata[7:0];
            end
         endcase
      end
   end

   // Bus state; the clock enable freezes it like everything else.
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         o_hrdata <= 32'h0;
         for (int u = 0; u < spwm_pkg::UNITS; u++) begin
            cfg[u] <= '0;
            cfg[u].mode_control_c <= spwm_pkg::MODE_CONTROL_C_RESET;
         end
         for (int c = 0; c < spwm_pkg::NCH; c++) begin
            duty[c] <= spwm_pkg::DUTY_RESET;
         end
      end else if (i_ce) begin
         wr_pend <= next_wr_pend;
         wr_addr <= next_wr_addr;
         o_hrdata <= next_hrdata;
         cfg <= next_cfg;
         duty <= next_duty;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Prescaler and channels.

   // One free-running prescaler per unit; a channel ticks when the low bits it
   // watches are all ones, so /2, /4 and /8 ticks line up across channels.
   always_comb begin
      for (int u = 0; u < spwm_pkg::UNITS; u++) begin
         next_presc[u] = presc[u] + 3'h1;
         cascade[u*3 +: 3] = {cfg[u].pair_select, cfg[u].mode_control_c[spwm_pkg::PAIR01_BIT]};
      end
   end

   // Each channel counts alone, or as half of a cascaded pair whose even half
   // owns the clock select. Pulse-division with a cascade is left to software.
   always_comb begin
      int u;
      int l;
      int e;
      int o;
      int ls;
      logic [1:0] sel;
      logic [2:0] mask;
      logic [15:0] wide;
      logic [15:0] wide_duty;
      u = 0;
      l = 0;
      e = 0;
      o = 0;
      ls = 0;
      sel = spwm_pkg::CLK_DIV1;
      mask = 3'h0;
      wide = 16'h0;
      wide_duty = 16'h0;
      for (int c = 0; c < spwm_pkg::NCH; c++) begin
         u = c / spwm_pkg::CHANS;
         l = c % spwm_pkg::CHANS;
         e = c - (l % 2);
         o = e + 1;
         ls = cascade[c/2] ? (l - (l % 2)) : l;
         sel = cfg[u].clock_select[2*ls +: 2];
         unique case (sel)
            spwm_pkg::CLK_DIV1: mask = 3'h0;
            spwm_pkg::CLK_DIV2: mask = 3'h1;
            spwm_pkg::CLK_DIV4: mask = 3'h3;
            spwm_pkg::CLK_DIV8: mask = 3'h7;
         endcase
         tick[c] = (presc[u] & mask) == mask;
         wide = {cnt[o], cnt[e]};
         wide_duty = {duty[o], duty[e]};
         next_cnt[c] = cnt[c];
         if (cascade[c/2]) begin
            // Cascaded: 65535-count period, duty 65535 keeps the output active.
            wave[c] = wide < wide_duty;
            if (tick[c]) begin
               wide = (wide == spwm_pkg::CASC_LAST) ? 16'h0 : wide + 16'h1;
            end
            next_cnt[c] = (c == o) ? wide[15:8] : wide[7:0];
         end else if (cfg[u].mode_control_c[l]) begin
            // Pulse division: sixteen short pulses per 256 counts.
            wave[c] = cnt[c][3:0] < duty[c][7:4];
            if (tick[c]) begin
               next_cnt[c] = cnt[c] + 8'h01;
            end
         end else begin
            // Single pulse: 255-count period, duty 255 keeps the output active.
            wave[c] = cnt[c] < duty[c];
            if (tick[c]) begin
               next_cnt[c] = (cnt[c] == spwm_pkg::SP_LAST) ? 8'h00 : cnt[c] + 8'h01;
            end
         end
         // A disabled output rests low regardless of the polarity bit.
         next_pwm[c] = cfg[u].out_enable[l] & (wave[c] ^ cfg[u].out_invert[l]);
      end
   end

   // Counters, prescalers and outputs; all hold while the clock enable is low.
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_pwm <= 12'h000;
         for (int u = 0; u < spwm_pkg::UNITS; u++) begin
            presc[u] <= 3'h0;
         end
         for (int c = 0; c < spwm_pkg::NCH; c++) begin
            cnt[c] <= 8'h00;
         end
      end else if (i_ce) begin
         o_pwm <= next_pwm;
         presc <= next_presc;
         cnt <= next_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   sequence s_presc_top;
      i_ce && presc[0] == 3'h7;
   endsequence

   sequence s_presc_zero;
      presc[0] == 3'h0;
   endsequence

   property p_prescale;
      s_presc_top |=> s_presc_zero;
   endproperty
   a_prescale: assert property (p_prescale) else $error("prescaler did not wrap");

   property p_div8_tick;
      cfg[0].clock_select[1:0] == spwm_pkg::CLK_DIV8 && !cascade[0]
         |-> tick[0] == (presc[0] == 3'h7);
   endproperty
   a_div8_tick: assert property (p_div8_tick) else $error("div8 tick wrong");

   property p_sp_wrap;
      i_ce && tick[0] && !cascade[0] && !cfg[0].mode_control_c[0] && cnt[0] == 8'hFE
         |=> cnt[0] == 8'h00;
   endproperty
   a_sp_wrap: assert property (p_sp_wrap) else $error("single-pulse period wrong");

   property p_pd_wrap;
      i_ce && tick[2] && !cascade[1] && cfg[0].mode_control_c[2] && cnt[2] == 8'hFF
         |=> cnt[2] == 8'h00;
   endproperty
   a_pd_wrap: assert property (p_pd_wrap) else $error("pulse-division wrap wrong");

   property p_casc_wrap;
      i_ce && tick[0] && cascade[0] && cnt[1] == 8'hFF && cnt[0] == 8'hFE
         |=> cnt[1] == 8'h00 && cnt[0] == 8'h00;
   endproperty
   a_casc_wrap: assert property (p_casc_wrap) else $error("cascade period wrong");

   property p_casc_carry;
      i_ce && tick[0] && cascade[0] && cnt[0] == 8'hFF && cnt[1] != 8'hFF
         |=> cnt[0] == 8'h00 && cnt[1] == $past(cnt[1]) + 8'h01;
   endproperty
   a_casc_carry: assert property (p_casc_carry) else $error("cascade carry lost");

   property p_disabled;
      i_ce && !cfg[0].out_enable[0] |=> !o_pwm[0];
   endproperty
   a_disabled: assert property (p_disabled) else $error("disabled output active");

   property p_invert;
      i_ce && cfg[0].out_enable[0] && cfg[0].out_invert[0] |=> o_pwm[0] == !$past(wave[0]);
   endproperty
   a_invert: assert property (p_invert) else $error("inverted output wrong");

   property p_full_duty;
      i_ce && !cascade[0] && !cfg[0].mode_control_c[0] && duty[0] == 8'hFF
         && cfg[0].out_enable[0] && !cfg[0].out_invert[0] |=> o_pwm[0];
   endproperty
   a_full_duty: assert property (p_full_duty) else $error("full duty not active");

   property p_pd_duty;
      i_ce && !cascade[0] && cfg[0].mode_control_c[0] && cfg[0].out_enable[0]
         && !cfg[0].out_invert[0] |=> o_pwm[0] == ($past(cnt[0][3:0]) < $past(duty[0][7:4]));
   endproperty
   a_pd_duty: assert property (p_pd_duty) else $error("sixteenth duty wrong");

   property p_freeze;
      !i_ce |=> $stable(cnt[0]) && $stable(o_pwm);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while frozen");

endmodule // spwm_timer

//--- rtl/spwm_pkg.sv
package spwm_pkg;

   // Geometry: two units of six channels each.
   localparam int UNITS = 2;
   localparam int CHANS = 6;
   localparam int NCH = 12;

   // Register byte offsets inside one unit; the second unit sits at UNIT_SECOND_BASE.
   localparam logic [7:0] OFS_MODE_CONTROL_C = 8'h00;
   localparam logic [7:0] OFS_PAIR_SELECT = 8'h04;
   localparam logic [7:0] OFS_CLOCK_SELECT = 8'h08;
   localparam logic [7:0] OFS_OUTPUT_CONFIG = 8'h0C;
   localparam logic [7:0] OFS_DUTY_BASE = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h28;
   localparam logic [7:0] UNIT_SECOND_BASE = 8'h40;

   // Word indices derived from the offsets above.
   localparam logic [3:0] WORD_MODE = 4'h0;
   localparam logic [3:0] WORD_PAIR = 4'h1;
   localparam logic [3:0] WORD_CLOCK = 4'h2;
   localparam logic [3:0] WORD_OUTPUT = 4'h3;
   localparam logic [3:0] WORD_DUTY0 = 4'h4;
   localparam logic [3:0] WORD_DUTY5 = 4'h9;
   localparam logic [3:0] WORD_STATUS = 4'hA;

   // Field positions.
   localparam int PAIR01_BIT = 6;
   localparam int RESERVED_BIT = 7;
   localparam int INVERT_POS = 8;

   // Values after reset.
   localparam logic [7:0] MODE_CONTROL_C_RESET = 8'h00;
   localparam logic [7:0] DUTY_RESET = 8'h00;

   // Last count of each period before the counter wraps to zero.
   localparam logic [7:0] SP_LAST = 8'hFE;
   localparam logic [15:0] CASC_LAST = 16'hFFFE;

   // Clock select codes: undivided, /2, /4, /8.
   localparam logic [1:0] CLK_DIV1 = 2'h0;
   localparam logic [1:0] CLK_DIV2 = 2'h1;
   localparam logic [1:0] CLK_DIV4 = 2'h2;
   localparam logic [1:0] CLK_DIV8 = 2'h3;

   // Software settings of one unit.
   typedef struct packed {
      logic [7:0] mode_control_c;
      logic [1:0] pair_select;
      logic [11:0] clock_select;
      logic [5:0] out_enable;
      logic [5:0] out_invert;
   } spwm_unit_cfg_type;

endpackage

//--- tb/spwm_load_model.sv
`timescale 1ns/1ns
// Stand-in for the filter behind the outputs: it integrates the high time of every output.
module spwm_load_model (
   input wire logic i_clock,
   input wire logic i_clear,
   input wire logic [11:0] i_pwm,
   output logic [16:0] o_high [12]
);
   // Integration restarts on clear, so each window is judged alone and no stale sum leaks in.
   always_ff @(posedge i_clock) begin
      for (int c = 0; c < 12; c++) begin
         o_high[c] <= i_clear ? 17'h00000 : o_high[c] + 17'(i_pwm[c]);
      end
   end
endmodule // spwm_load_model

//--- tb/spwm_timer_tb_top.sv
`timescale 1ns/1ns
module spwm_timer_tb_top;
   logic i_clock = 1'b0;
   logic i_rst = 1'b1;
   logic i_ce = 1'b1;
   logic i_hsel = 1'b0;
   logic [31:0] i_haddr = 32'h00000000;
   logic [1:0] i_htrans = 2'h0;
   logic i_hwrite = 1'b0;
   logic [2:0] i_hsize = 3'h2;
   logic [31:0] i_hwdata = 32'h00000000;
   logic o_hreadyout;
   logic o_hresp;
   logic [31:0] o_hrdata;
   logic [11:0] o_pwm;
   logic clear = 1'b0;
   logic [16:0] high [12];
   logic [16:0] e;
   logic [31:0] rd;
   logic resp = 1'b0;
   int error_cnt = 0;
   int num_checks = 0;
   // Duties packed ch5 down to ch0; clock codes 0,1,2,3,0,1; ch3 and ch4 inverted, ch4 disabled.
   localparam logic [47:0] D0 = 48'hFE0580FF02FF;
   localparam logic [47:0] D1 = 48'h103080F04F00;
   localparam logic [47:0] D2 = 48'hFFFF80000102;
   localparam logic [31:0] CLKS = 32'h000004E4;
   localparam logic [31:0] OC = 32'h0000182F;
   // Cascade test inverts ch0, ch2 and ch3; the last test mixes modes on the first unit.
   localparam logic [31:0] OC3 = 32'h00000D3F;
   localparam logic [47:0] D3 = 48'h33FF00A54070;
   localparam logic [31:0] MODE3 = 32'h00000005;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Clock of 100 ns period.
   always #50 i_clock = ~i_clock;

   // The single slave's ready is the bus ready.
   spwm_timer dut (.i_clock(i_clock), .i_rst(i_rst), .i_ce(i_ce), .i_hsel(i_hsel),
      .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize),
      .i_hwdata(i_hwdata), .i_hready(o_hreadyout), .o_hreadyout(o_hreadyout),
      .o_hresp(o_hresp), .o_hrdata(o_hrdata), .o_pwm(o_pwm));
   spwm_load_model load (.i_clock(i_clock), .i_clear(clear), .i_pwm(o_pwm), .o_high(high));

   ////////////////////////////////////////////////////////////////////////////////////////////
   // One single word transfer; read data is taken at the edge that ends the data phase.
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge i_clock);
      i_hsel <= 1'b1;
      i_haddr <= a;
      i_hwrite <= w;
      i_htrans <= 2'h2;
      @(posedge i_clock);
      while (o_hreadyout !== 1'b1) @(posedge i_clock);
      i_htrans <= 2'h0;
      i_hsel <= 1'b0;
      i_hwdata <= d;
      @(posedge i_clock);
      while (o_hreadyout !== 1'b1) @(posedge i_clock);
      rd = o_hrdata;
      resp = o_hresp;
   endtask

   function automatic logic [31:0] ra(input int u, input logic [7:0] ofs);
      return {24'h000000, ofs + (u == 1 ? spwm_pkg::UNIT_SECOND_BASE : 8'h00)};
   endfunction

   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic chk_high(input logic [16:0] got, input logic [16:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: high %0h expected %0h", $time, got, exp);
      end
   endtask

   // Mode is written last, so the new wave starts only after duty and clocks are settled.
   task automatic cfg(input int u, input logic [31:0] mode, input logic [31:0] clk,
         input logic [31:0] oc, input logic [47:0] dt);
      for (int c = 0; c < 6; c++) begin
         bus(1'b1, ra(u, spwm_pkg::OFS_DUTY_BASE + 8'(4 * c)), {24'h000000, dt[8*c+:8]});
      end
      bus(1'b1, ra(u, spwm_pkg::OFS_CLOCK_SELECT), clk);
      bus(1'b1, ra(u, spwm_pkg::OFS_OUTPUT_CONFIG), oc);
      bus(1'b1, ra(u, spwm_pkg::OFS_MODE_CONTROL_C), mode);
   endtask

   // A window of whole periods makes the sum independent of where the counters stand.
   task automatic measure(input int n);
      @(posedge i_clock);
      clear <= 1'b1;
      @(posedge i_clock);
      clear <= 1'b0;
      repeat (n) @(posedge i_clock);
      #1;
   endtask

   function automatic logic [16:0] exp_high(input logic [7:0] d, input logic pd,
         input logic en, input logic inv, input int w);
      logic [16:0] x;
      x = pd ? 17'(d[7:4]) * 17'(w / 16) : 17'(d) * 17'(w / 255);
      if (inv) x = 17'(w) - x;
      return en ? x : 17'h00000;
   endfunction

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Watchdog sized a little above the whole run of about 74,000 cycles.
   initial begin
      #9000000;
      error_cnt++;
      tally_and_finish;
   end

   // Main sequence.
   initial begin
      repeat (12) @(posedge i_clock);
      i_rst <= 1'b0;
      bus(1'b0, ra(0, spwm_pkg::OFS_MODE_CONTROL_C), 32'h00000000);
      chk_reg(rd, {24'h000000, spwm_pkg::MODE_CONTROL_C_RESET});
      chk_reg({20'h00000, o_pwm}, 32'h00000000);
      bus(1'b1, ra(1, spwm_pkg::OFS_MODE_CONTROL_C), 32'h0000004C);
      bus(1'b0, ra(1, spwm_pkg::OFS_MODE_CONTROL_C), 32'h00000000);
      chk_reg(rd, 32'h0000004C);
      bus(1'b1, 32'h0000003C, 32'hFFFFFFFF);
      bus(1'b0, 32'h0000003C, 32'h00000000);
      chk_reg(rd, 32'h00000000);
      chk_reg({31'h00000000, resp}, 32'h00000000);
      $display("test registers done");
      cfg(0, 32'h00000000, CLKS, OC, D0);
      cfg(1, 32'h0000003F, CLKS, OC, D1);
      measure(2040);
      for (int c = 0; c < 6; c++) begin
         chk_high(high[c], exp_high(D0[8*c+:8], 1'b0, OC[c], OC[8+c], 2040));
      end
      // Channels 0 and 2 sit at full duty and channel 4 is disabled; the rest move.
      bus(1'b0, ra(0, spwm_pkg::OFS_STATUS), 32'h00000000);
      chk_reg(rd & 32'hFFFFFFD5, 32'h00000005);
      measure(2048);
      for (int c = 0; c < 6; c++) begin
         chk_high(high[6+c], exp_high(D1[8*c+:8], 1'b1, OC[c], OC[8+c], 2048));
      end
      $display("test single pulse and pulse division done");
      bus(1'b1, ra(0, spwm_pkg::OFS_PAIR_SELECT), 32'h00000003);
      cfg(0, 32'h00000040, 32'h00000000, OC3, D2);
      measure(65535);
      for (int c = 0; c < 6; c++) begin
         e = 17'(D2[16*(c/2)+:16]);
         if (OC3[8+c]) e = 17'h0FFFF - e;
         chk_high(high[c], e);
      end
      $display("test cascade done");
      bus(1'b1, ra(0, spwm_pkg::OFS_PAIR_SELECT), 32'h00000000);
      cfg(0, MODE3, 32'h00000000, 32'h0000003F, D3);
      // A pulse-division output toggles within a few cycles, so a frozen one must not.
      @(posedge i_clock);
      i_ce <= 1'b0;
      @(posedge i_clock);
      rd = {20'h00000, o_pwm};
      repeat (20) @(posedge i_clock);
      chk_reg({20'h00000, o_pwm}, rd);
      i_ce <= 1'b1;
      // 4080 cycles hold whole periods of both the 255-count and the 16-count wave.
      measure(4080);
      for (int c = 0; c < 6; c++) begin
         chk_high(high[c], exp_high(D3[8*c+:8], MODE3[c], 1'b1, 1'b0, 4080));
      end
      $display("test freeze and mixed modes done");
      tally_and_finish;
   end
endmodule // spwm_timer_tb_top
